// *** hw/counter_array_outputs.sv ***
// Purpose: compare/output side of a 16-bit counter array with watchdog on module 4
// Assumes: apb slave, inputs synchronous to pclk
// Notes: capture mode is not implemented
//
// Contract
// R01 - toggle mode: invert pin whenever 16-bit counter equals compare word
// R02 - low compare byte write clears compare enable, high byte write sets it
// R03 - frequency mode: low byte match toggles pin and adds high to low
// R04 - high byte zero gives half-period of 256 counter clocks
// R05 - frequency mode selected by compare, toggle and pwm enables
// R06 - 8-bit pwm: pin high on low byte match, low on low byte overflow
// R07 - 8-bit pwm: low compare byte reloads from high byte on wrap
// R08 - 8-bit pwm when compare and pwm set, wide select clear
// R09 - compare enable clear gives 0% duty, zero compare gives 100%
// R10 - 16-bit pwm: pin high on word match, low on counter overflow
// R11 - 16-bit pwm when compare, pwm and wide select set
// R12 - software should time duty changes to match events
// R13 - watchdog enable or lock makes module 4 a watchdog
// R14 - reset: watchdog on, timebase div 12, counter low and offset zero
// R15 - watchdog on: counter forced running, counter/module4 mode/timebase/idle writes ignored
// R16 - watchdog on: run bit write never stops counter, reads as software set
// R17 - update write loads counter high byte plus offset
// R18 - watchdog reset when low byte overflows with high byte match
// R19 - writing 1 to module 4 flag forces watchdog reset
// R20 - lock keeps watchdog on until reset, else enable clear disables
// R21 - software configures watchdog with enable clear first
// R22 - timeout is 256 times offset plus 256 minus low byte
// R23 - timebase select picks one of six counter sources
// R24 - compare match sets sticky event flag until software clears
// R25 - all comparisons happen on pclk cycles where counter advances
`timescale 1ns/100ps
module counter_array_outputs
	import counter_array_pkg::*;
#(
	parameter int N = NUM_MODULES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer0_overflow,
	input wire logic external_count_input,
	input wire logic ext_osc_tick,
	input wire logic cpu_idle,
	output logic [N-1:0] module_io_pin,
	output logic [N-1:0] module_event_flag,
	output logic watchdog_reset
);
	// ************************************************
	// bus decode
	// ************************************************
	logic pready_reg;
	// one wait state: first access cycle loads read data, second completes
	wire acc = psel && penable;
	wire wr_en = acc && pready_reg && pwrite && pstrb[0];
	wire rd_load = acc && !pready_reg && !pwrite;
	wire [7:0] wd = pwdata[7:0];
	wire mod_region = (paddr >= MOD_BASE_OFF) && (paddr < MOD_END_OFF);
	wire [7:0] mod_rel = paddr - MOD_BASE_OFF;
	wire [3:0] mod_idx = mod_rel[7:4];
	wire [7:0] mod_sub = {4'h0, mod_rel[3:0]};
	wire wr_ctrl = wr_en && paddr == CTRL_OFF;
	wire wr_mode = wr_en && paddr == MODE_OFF;
	wire wr_cnt_low = wr_en && paddr == CNT_LOW_OFF;
	wire wr_cnt_high = wr_en && paddr == CNT_HIGH_OFF;
	wire addr_ok = paddr[1:0] == 2'b00 && (paddr <= CNT_HIGH_OFF ||
		(mod_region && mod_sub <= MOD_MODE_OFF));

	// ************************************************
	// state
	// ************************************************
	logic [15:0] counter_reg;
	logic run_reg;
	logic [2:0] timebase_reg;
	logic idle_suspend_reg;
	logic wde_reg;
	logic lock_reg;
	logic [7:0] snap_reg;
	logic [3:0] div_reg;
	logic [2:0] osc_div_reg;
	logic extin_prev_reg;
	word_t cmp_reg [N];
	module_mode_t mm_reg [N];
	logic [N-1:0] pin_reg;
	logic [N-1:0] flag_reg;
	logic wdt_rst_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	wire wdt_on = wde_reg || lock_reg; // R13
	wire run_eff = run_reg || wdt_on; // R15 R16
	wire suspended = idle_suspend_reg && cpu_idle;
	wire [3:0] div_last = (timebase_reg == TB_DIV4) ? DIV4_LAST : DIV12_LAST;
	wire div_wrap = div_reg == div_last;
	wire osc_tick_out = ext_osc_tick && osc_div_reg == DIV8_LAST;
	wire extin_fall = extin_prev_reg && !external_count_input;
	logic tb_tick;
	always_comb begin
		case (timebase_reg) // R23
			TB_DIV12, TB_DIV4: tb_tick = div_wrap;
			TB_TIMER0: tb_tick = timer0_overflow;
			TB_EXTIN: tb_tick = extin_fall;
			TB_SYSCLK: tb_tick = 1'b1;
			TB_EXTOSC: tb_tick = osc_tick_out;
			default: tb_tick = 1'b0;
		endcase
	end
	wire adv = tb_tick && run_eff && !suspended; // R25
	wire [15:0] cnt_next = counter_reg + 16'h0001;
	wire low_ovf = adv && counter_reg[7:0] == 8'hff;
	wire word_ovf = adv && counter_reg == 16'hffff;

	function automatic module_op_t decode_op(input module_mode_t m);
		if (!m.compare_enable && m.pwm_enable)
			decode_op = m.wide_pwm_select ? MODE_PWM16 : MODE_PWM8;
		else if (!m.compare_enable)
			decode_op = MODE_IDLE;
		else if (m.toggle_enable && m.pwm_enable)
			decode_op = MODE_FREQ; // R05
		else if (m.pwm_enable)
			decode_op = m.wide_pwm_select ? MODE_PWM16 : MODE_PWM8; // R08 R11
		else if (m.toggle_enable && m.match_enable)
			decode_op = MODE_TOGGLE; // R01
		else
			decode_op = MODE_IDLE;
	endfunction

	function automatic module_mode_t to_mode(input logic [7:0] b);
		to_mode.wide_pwm_select = b[MM_WIDE_BIT];
		to_mode.compare_enable = b[MM_CMP_BIT];
		to_mode.match_enable = b[MM_MATCH_BIT];
		to_mode.toggle_enable = b[MM_TOG_BIT];
		to_mode.pwm_enable = b[MM_PWM_BIT];
		to_mode.module_interrupt_enable = b[MM_IE_BIT];
	endfunction

	function automatic logic [7:0] from_mode(input module_mode_t m);
		from_mode = 8'h00;
		from_mode[MM_WIDE_BIT] = m.wide_pwm_select;
		from_mode[MM_CMP_BIT] = m.compare_enable;
		from_mode[MM_MATCH_BIT] = m.match_enable;
		from_mode[MM_TOG_BIT] = m.toggle_enable;
		from_mode[MM_PWM_BIT] = m.pwm_enable;
		from_mode[MM_IE_BIT] = m.module_interrupt_enable;
	endfunction

	// ************************************************
	// timebase and counter
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 4'h0;
			osc_div_reg <= 3'h0;
			extin_prev_reg <= 1'b1;
		end else begin
			div_reg <= div_wrap ? 4'h0 : div_reg + 4'h1;
			if (ext_osc_tick)
				osc_div_reg <= osc_div_reg + 3'h1;
			extin_prev_reg <= external_count_input;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_reg <= {BYTE_RESET, BYTE_RESET}; // R14
		end else if (wr_cnt_low && !wdt_on) begin // R15
			counter_reg[7:0] <= wd;
		end else if (wr_cnt_high && !wdt_on) begin // R15
			counter_reg[15:8] <= wd;
		end else if (adv) begin
			counter_reg <= cnt_next;
		end
	end

	// ************************************************
	// mode and control registers
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_reg <= 1'b0;
			timebase_reg <= TB_RESET; // R14
			idle_suspend_reg <= 1'b0;
			wde_reg <= 1'b1; // R14
			lock_reg <= 1'b0;
		end else begin
			if (wr_ctrl)
				run_reg <= wd[CTRL_RUN_BIT]; // R16
			if (wr_mode) begin
				if (!wdt_on) begin // R15
					timebase_reg <= wd[MODE_TB_LSB +: 3];
					idle_suspend_reg <= wd[MODE_IDLE_BIT];
				end
				wde_reg <= wd[MODE_WDE_BIT]; // R20
				lock_reg <= lock_reg || wd[MODE_LOCK_BIT]; // R20
			end
		end
	end

	// ************************************************
	// compare modules
	// ************************************************
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : gen_mod
			localparam logic [3:0] IDX = 4'(g);
			wire is_wdt = g == WDT_MODULE && wdt_on;
			wire sel = wr_en && mod_region && mod_idx == IDX;
			wire wr_lo = sel && mod_sub == MOD_CMP_LOW_OFF;
			wire wr_hi = sel && mod_sub == MOD_CMP_HIGH_OFF;
			wire wr_mm = sel && mod_sub == MOD_MODE_OFF && !is_wdt; // R15
			module_op_t op;
			assign op = is_wdt ? MODE_IDLE : decode_op(mm_reg[g]);
			wire m_word = adv && counter_reg == cmp_reg[g];
			wire m_low = adv && counter_reg[7:0] == cmp_reg[g].low;
			// pwm sets as the counter reaches the compare value, so duty is exact
			wire n_low = adv && cnt_next[7:0] == cmp_reg[g].low;
			wire n_word = adv && cnt_next == cmp_reg[g];
			wire cmp_on = mm_reg[g].compare_enable;
			wire match_ev = (op == MODE_TOGGLE || op == MODE_PWM16) ? m_word :
				(op == MODE_FREQ || op == MODE_PWM8) ? m_low :
				(!is_wdt && cmp_on && mm_reg[g].match_enable && m_word);
			wire clr_flag = wr_ctrl && !wd[g];
			wire force_rst = g == WDT_MODULE && wr_ctrl && wd[g] && wdt_on; // R19
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cmp_reg[g] <= {BYTE_RESET, BYTE_RESET}; // R14
					mm_reg[g] <= '0;
					pin_reg[g] <= 1'b0;
					flag_reg[g] <= 1'b0;
				end else begin
					if (wr_mm)
						mm_reg[g] <= to_mode(wd);
					if (wr_lo && !is_wdt)
						mm_reg[g].compare_enable <= 1'b0; // R02
					if (wr_hi && !is_wdt)
						mm_reg[g].compare_enable <= 1'b1; // R02
					if (wr_lo)
						cmp_reg[g].low <= wd;
					if (wr_hi && is_wdt)
						cmp_reg[g].high <= counter_reg[15:8] + cmp_reg[g].low; // R17 R22
					else if (wr_hi)
						cmp_reg[g].high <= wd;
					else if (op == MODE_FREQ && m_low)
						cmp_reg[g].low <= cmp_reg[g].low + cmp_reg[g].high; // R03 R04
					else if (op == MODE_PWM8 && low_ovf)
						cmp_reg[g].low <= cmp_reg[g].high; // R07
					case (op)
						MODE_TOGGLE: if (m_word) pin_reg[g] <= !pin_reg[g]; // R01
						MODE_FREQ: if (m_low) pin_reg[g] <= !pin_reg[g]; // R03
						MODE_PWM8: begin
							if (!cmp_on) pin_reg[g] <= 1'b0; // R09
							else if (n_low) pin_reg[g] <= 1'b1; // R06 R09
							else if (low_ovf) pin_reg[g] <= 1'b0; // R06
						end
						MODE_PWM16: begin
							if (!cmp_on) pin_reg[g] <= 1'b0; // R09
							else if (n_word) pin_reg[g] <= 1'b1; // R10 R09
							else if (word_ovf) pin_reg[g] <= 1'b0; // R10
						end
						default: pin_reg[g] <= pin_reg[g];
					endcase
					if (match_ev)
						flag_reg[g] <= 1'b1; // R24
					else if (clr_flag && !force_rst)
						flag_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ************************************************
	// watchdog reset
	// ************************************************
	wire wdt_hit = wdt_on && low_ovf &&
		cmp_reg[WDT_MODULE].high == counter_reg[15:8]; // R18
	wire wdt_force = wdt_on && wr_ctrl && wd[WDT_MODULE]; // R19
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wdt_rst_reg <= 1'b0;
		else
			wdt_rst_reg <= wdt_hit || wdt_force; // R18 R19
	end

	// ************************************************
	// read path
	// ************************************************
	logic [7:0] rd_byte;
	wire [2:0] mi = mod_idx[2:0];
	always_comb begin
		rd_byte = 8'h00;
		if (paddr == CTRL_OFF) begin
			rd_byte[CTRL_RUN_BIT] = run_reg; // R16
			rd_byte[N-1:0] = flag_reg;
		end else if (paddr == MODE_OFF) begin
			rd_byte[MODE_IDLE_BIT] = idle_suspend_reg;
			rd_byte[MODE_WDE_BIT] = wde_reg;
			rd_byte[MODE_LOCK_BIT] = lock_reg;
			rd_byte[MODE_TB_LSB +: 3] = timebase_reg;
		end else if (paddr == CNT_LOW_OFF) begin
			rd_byte = counter_reg[7:0];
		end else if (paddr == CNT_HIGH_OFF) begin
			rd_byte = snap_reg;
		end else if (mod_region && mod_sub == MOD_CMP_LOW_OFF) begin
			rd_byte = cmp_reg[mi].low;
		end else if (mod_region && mod_sub == MOD_CMP_HIGH_OFF) begin
			rd_byte = cmp_reg[mi].high;
		end else if (mod_region && mod_sub == MOD_MODE_OFF) begin
			rd_byte = from_mode(mm_reg[mi]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			snap_reg <= 8'h00;
			pready_reg <= 1'b0;
		end else begin
			if (rd_load && paddr == CNT_LOW_OFF)
				snap_reg <= counter_reg[15:8];
			prdata_reg <= (rd_load && addr_ok) ? {24'h000000, rd_byte} : 32'h0000_0000;
			pslverr_reg <= acc && !pready_reg && !addr_ok;
			pready_reg <= acc && !pready_reg;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign module_io_pin = pin_reg;
	assign module_event_flag = flag_reg;
	assign watchdog_reset = wdt_rst_reg;
endmodule

// *** hw/counter_array_pkg.sv ***
// Purpose: shared constants and types for the counter array output block
// Assumes: apb with 32-bit data, one register per aligned word
// Notes: module count fixed at five, module 4 doubles as watchdog
package counter_array_pkg;
	localparam int NUM_MODULES = 5;
	localparam int WDT_MODULE = 4;
	// register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] MODE_OFF = 8'h04;
	localparam logic [7:0] CNT_LOW_OFF = 8'h08;
	localparam logic [7:0] CNT_HIGH_OFF = 8'h0c;
	localparam logic [7:0] MOD_BASE_OFF = 8'h10;
	localparam logic [7:0] MOD_STRIDE = 8'h10;
	localparam logic [7:0] MOD_CMP_LOW_OFF = 8'h00;
	localparam logic [7:0] MOD_CMP_HIGH_OFF = 8'h04;
	localparam logic [7:0] MOD_MODE_OFF = 8'h08;
	localparam logic [7:0] MOD_END_OFF = 8'h60;
	// counter_control_reg fields
	localparam int CTRL_RUN_BIT = 6;
	// counter_mode_reg fields
	localparam int MODE_IDLE_BIT = 7;
	localparam int MODE_WDE_BIT = 6;
	localparam int MODE_LOCK_BIT = 5;
	localparam int MODE_TB_LSB = 1;
	// module_mode_reg fields
	localparam int MM_WIDE_BIT = 7;
	localparam int MM_CMP_BIT = 6;
	localparam int MM_MATCH_BIT = 3;
	localparam int MM_TOG_BIT = 2;
	localparam int MM_PWM_BIT = 1;
	localparam int MM_IE_BIT = 0;
	// reset values
	localparam logic [2:0] TB_RESET = 3'h0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// timebase codes
	localparam logic [2:0] TB_DIV12 = 3'h0;
	localparam logic [2:0] TB_DIV4 = 3'h1;
	localparam logic [2:0] TB_TIMER0 = 3'h2;
	localparam logic [2:0] TB_EXTIN = 3'h3;
	localparam logic [2:0] TB_SYSCLK = 3'h4;
	localparam logic [2:0] TB_EXTOSC = 3'h5;
	localparam logic [3:0] DIV12_LAST = 4'hb;
	localparam logic [3:0] DIV4_LAST = 4'h3;
	localparam logic [2:0] DIV8_LAST = 3'h7;

	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_TOGGLE,
		MODE_FREQ,
		MODE_PWM8,
		MODE_PWM16
	} module_op_t;

	typedef struct packed {
		logic wide_pwm_select;
		logic compare_enable;
		logic match_enable;
		logic toggle_enable;
		logic pwm_enable;
		logic module_interrupt_enable;
	} module_mode_t;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} word_t;
endpackage

// *** verification/count_source_model.sv ***
// Purpose: outside source feeding the external count input
// Assumes: level toggles every third pclk cycle
// Notes: gives one falling edge per six cycles
`timescale 1ns/100ps
module count_source_model (
	input wire logic pclk,
	output logic count_in
);
	logic [1:0] div_reg = 2'h0;
	initial count_in = 1'b1;
	always @(posedge pclk) begin
		div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
		if (div_reg == 2'h2) count_in <= ~count_in;
	end
endmodule

// *** verification/counter_array_outputs_bench.sv ***
// Purpose: self-checking bench for the counter array output block
// Assumes: read data sampled at the edge where pready is high
// Notes: reads are queued and compared by a monitor
`timescale 1ns/100ps
module counter_array_outputs_bench
	import counter_array_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic timer0_overflow = 1'b0, ext_osc_tick = 1'b0, cpu_idle = 1'b0;
	logic external_count_input, pready, pslverr, watchdog_reset, err;
	logic [4:0] module_io_pin, module_event_flag;
	logic [31:0] exp_q[$], msk_q[$];
	int n_mismatch = 0, comparisons = 0, cyc_n = 0;
	initial begin
		forever #50 pclk = ~pclk;
	end
	counter_array_outputs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
		.ext_osc_tick(ext_osc_tick), .cpu_idle(cpu_idle), .module_io_pin(module_io_pin),
		.module_event_flag(module_event_flag), .watchdog_reset(watchdog_reset));
	count_source_model partner (.pclk(pclk), .count_in(external_count_input));
	// *****
	// tasks
	// *****
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wait_chg(input int i, output int g);
		logic v;
		v = module_io_pin[i];
		g = 0;
		while (module_io_pin[i] === v && g < 2000) begin
			@(posedge pclk);
			g++;
		end
	endtask
	task automatic duty(input int i, input int n, output int h);
		h = 0;
		repeat (n) begin
			@(posedge pclk);
			if (module_io_pin[i] === 1'b1) h++;
		end
	endtask
	task automatic wait_wd(input int lim, output int k);
		k = 0;
		while (watchdog_reset !== 1'b1 && k < lim) begin
			@(posedge pclk);
			k++;
		end
	endtask
	always @(posedge pclk) begin
		if (psel && penable && !pwrite && pready === 1'b1)
			chk("prdata", exp_q.pop_front(), prdata & msk_q.pop_front());
		cyc_n++;
		if (cyc_n == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		int g, h;
		logic [7:0] hb;
		int tbs[4] = '{1, 3, 4, 4};
		int dv[4] = '{4, 6, 1, 1};
		void'($urandom(32'hb501321f));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(MODE_OFF, 32'h40, 32'hee);
		wait_wd(3300, g);
		chk("wd_first", 32'h1, {31'h0, g > 3000 && g < 3150});
		$display("test reset_watchdog done");
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		wr(MODE_OFF, 32'h0);
		wr(MODE_OFF, 32'h08);
		rd(MODE_OFF, 32'h08, 32'hee);
		wr(CTRL_OFF, 32'h5f);
		rd(8'hfc, 32'h0, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err});
		wr(8'h18, 32'h4c);
		wr(8'h10, 32'h80);
		rd(8'h18, 32'h00, 32'h40);
		hb = 8'($urandom_range(254, 1));
		wr(8'h14, {24'h0, hb});
		rd(8'h18, 32'h40, 32'h40);
		wr(CNT_LOW_OFF, 32'h40);
		wr(CNT_HIGH_OFF, {24'h0, hb});
		g = 0;
		while (module_event_flag[0] !== 1'b1 && g < 300) begin
			@(posedge pclk);
			g++;
		end
		chk("toggle_gap", 32'h1, {31'h0, g > 55 && g < 70});
		chk("pin0", 32'h1, {31'h0, module_io_pin[0]});
		wr(CTRL_OFF, 32'h5e);
		@(posedge pclk);
		chk("flag0", 32'h0, {31'h0, module_event_flag[0]});
		$display("test toggle done");
		wr(8'h28, 32'h46);
		for (int i = 0; i < 4; i++) begin
			hb = (i == 3) ? 8'h00 : 8'($urandom_range(6, 1));
			wr(MODE_OFF, 32'(tbs[i] << 1));
			wr(8'h20, 32'h0);
			wr(8'h24, {24'h0, hb});
			wait_chg(1, g);
			wait_chg(1, g);
			chk("freq_gap", 32'(dv[i] * ((hb == 0) ? 256 : hb)), 32'(g));
		end
		$display("test frequency done");
		wr(8'h38, 32'h42);
		for (int i = 0; i < 2; i++) begin
			hb = i ? 8'($urandom_range(255, 1)) : 8'h00;
			wr(8'h30, {24'h0, hb});
			wr(8'h34, {24'h0, hb});
			repeat (300) @(posedge pclk);
			duty(2, 512, h);
			chk("pwm8_high", 32'(512 - 2 * hb), 32'(h));
		end
		wr(8'h30, 32'h0);
		repeat (4) @(posedge pclk);
		duty(2, 300, h);
		chk("pwm8_off", 32'h0, 32'(h));
		wr(8'h48, 32'hc2);
		wr(8'h40, 32'hf0);
		wr(8'h44, 32'hff);
		wr(CNT_LOW_OFF, 32'hc0);
		wr(CNT_HIGH_OFF, 32'hff);
		duty(3, 128, h);
		chk("pwm16_high", 32'd16, 32'(h));
		$display("test pwm done");
		wr(8'h50, 32'h01);
		wr(MODE_OFF, 32'h68);
		wr(MODE_OFF, 32'h08);
		wr(8'h54, 32'h0);
		wait_wd(700, g);
		chk("wd_timeout", 32'h1, {31'h0, g >= 250 && g <= 520});
		wr(CTRL_OFF, 32'h7f);
		wait_wd(4, g);
		chk("wd_forced", 32'h1, {31'h0, g < 4});
		$display("test watchdog done");
		test_done();
	end
endmodule
bind counter_array_outputs counter_array_outputs_checker #(.N(N)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
	.ext_osc_tick(ext_osc_tick), .cpu_idle(cpu_idle), .module_io_pin(module_io_pin),
	.module_event_flag(module_event_flag), .watchdog_reset(watchdog_reset));

// *** verification/counter_array_outputs_props.sv ***
// Purpose: port-level checks for the counter array output block
// Assumes: apb writes land at the access edge
// Notes: helper state mirrors watchdog enable and two module modes
`timescale 1ns/100ps
module counter_array_outputs_checker
	import counter_array_pkg::*;
#(
	parameter int N = NUM_MODULES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic timer0_overflow,
	input wire logic external_count_input,
	input wire logic ext_osc_tick,
	input wire logic cpu_idle,
	input wire logic [N-1:0] module_io_pin,
	input wire logic [N-1:0] module_event_flag,
	input wire logic watchdog_reset
);
	logic wd_on_reg, lock_reg, wrote_reg;
	logic [7:0] m0_reg, m2_reg;
	logic [15:0] cnt_reg;
	wire wr = psel && penable && pready && pwrite && pstrb[0];
	wire wr_mode = wr && paddr == MODE_OFF;
	// ************
	// mirror state
	// ************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_on_reg <= 1'b1;
			lock_reg <= 1'b0;
			wrote_reg <= 1'b0;
			m0_reg <= 8'h00;
			m2_reg <= 8'h00;
			cnt_reg <= 16'h0000;
		end else begin
			if (cnt_reg != 16'hffff) cnt_reg <= cnt_reg + 16'h0001;
			if (wr) wrote_reg <= 1'b1;
			if (wr_mode && !lock_reg) wd_on_reg <= pwdata[6] | pwdata[5];
			if (wr_mode) lock_reg <= lock_reg | pwdata[5];
			if (wr && paddr == 8'h18) m0_reg <= pwdata[7:0];
			else if (wr && paddr == 8'h10) m0_reg[6] <= 1'b0;
			else if (wr && paddr == 8'h14) m0_reg[6] <= 1'b1;
			if (wr && paddr == 8'h38) m2_reg <= pwdata[7:0];
			else if (wr && paddr == 8'h30) m2_reg[6] <= 1'b0;
			else if (wr && paddr == 8'h34) m2_reg[6] <= 1'b1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	AST_RDATA_IDLE: assert property (!(psel && penable && !pwrite) |=> prdata == 32'h0)
		else $error("read data not cleared");
	AST_FLAG_STICKY: assert property ($fell(module_event_flag[0]) |->
		$past(wr && paddr == CTRL_OFF && !pwdata[0]))
		else $error("flag fell without clear");
	AST_FORCE_RESET: assert property (wr && paddr == CTRL_OFF && pwdata[4] && wd_on_reg
		|=> watchdog_reset)
		else $error("forced watchdog reset missing");
	AST_WD_ONLY_ON: assert property (watchdog_reset |-> $past(wd_on_reg))
		else $error("watchdog reset while disabled");
	AST_WD_PULSE: assert property (watchdog_reset |=> !watchdog_reset)
		else $error("watchdog reset too long");
	AST_FIRST_TIMEOUT: assert property (watchdog_reset && !wrote_reg |->
		cnt_reg >= 16'd3060 && cnt_reg <= 16'd3100)
		else $error("default timeout wrong");
	AST_TOGGLE_FLAG: assert property (m0_reg == 8'h4c && $changed(module_io_pin[0])
		|-> ##[0:1] module_event_flag[0])
		else $error("toggle without match flag");
	AST_PWM_OFF: assert property ((m2_reg[1] && !m2_reg[6] && !m2_reg[2]) [*3]
		|-> !module_io_pin[2])
		else $error("pwm pin high with compare off");
endmodule
